// ==== logic/msf_top.sv ====
// Purpose: configuration registers, output polarity, mode decode and z filtering
// Assumes: Avalon-MM slave, one wait state on every access
// Notes: all outputs registered
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module msf_top (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_three_phase_independent,
  input wire logic i_sensor_mode_select,
  input wire logic i_master_output_enable,
  input wire logic i_pwm_sample_mode,
  input wire logic i_pwm_tick,
  input wire logic i_d_event,
  input wire logic i_z_sample,
  input wire logic i_tacho_in,
  input wire logic i_rtc_tick,
  input wire logic i_motor_timer_high_read,
  input wire logic [5:0] i_channel,
  output logic [5:0] o_channel,
  output logic o_speed_sensor_mode,
  output logic o_tacho_capture,
  output logic o_encoder_capture,
  output logic o_encoder_capture_source,
  output logic o_inputs_ground,
  output logic o_inputs_hiz,
  output logic o_z_event,
  output logic o_blanking
);
  // ****************************************
  // registers
  // ****************************************
  logic [7:0] output_polarity_tacho_edge, next_output_polarity_tacho_edge;
  logic [7:0] z_event_filter, next_z_event_filter;
  logic [7:0] sampling_clock_config, next_sampling_clock_config;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic [2:0] pdiv, next_pdiv;
  logic tacho_d;
  msf_cfg_if cfg ();

  logic [1:0] tacho_edge_select;
  logic speed_mode;
  logic unused_in_eff;
  logic z_blank_active, z_ev;
  assign tacho_edge_select =
    output_polarity_tacho_edge[msf_pkg::TACHO_SEL_HI:msf_pkg::TACHO_SEL_LO];
  assign speed_mode = (tacho_edge_select != 2'h0);
  assign unused_in_eff = !i_three_phase_independent && !speed_mode &&
                         !i_sensor_mode_select;

  // writes are taken only on the wait-state-free edge; read data is registered on the wait-state edge
  logic bus_req;
  logic bus_take;
  assign bus_req = i_avs_read || i_avs_write;
  assign bus_take = bus_req && !o_avs_waitrequest;

  always_comb begin
    next_output_polarity_tacho_edge = output_polarity_tacho_edge;
    next_z_event_filter = z_event_filter;
    next_sampling_clock_config = sampling_clock_config;
    next_readdata = o_avs_readdata;
    next_waitrequest = !(bus_req && o_avs_waitrequest);
    if (!bus_req) begin
      next_waitrequest = 1'b1;
    end
    if (bus_take && i_avs_write && i_avs_byteenable[0]) begin
      if (i_avs_address == msf_pkg::ADDR_POLARITY_TACHO) begin
        next_output_polarity_tacho_edge = i_avs_writedata[7:0];
      end else if (i_avs_address == msf_pkg::ADDR_Z_FILTER) begin
        next_z_event_filter = i_avs_writedata[7:0];
      end else if (i_avs_address == msf_pkg::ADDR_SAMPLING_CLK) begin
        // reserved bits kept zero even if software disobeys
        next_sampling_clock_config = i_avs_writedata[7:0] & msf_pkg::SCR_WRITE_MASK;
      end
    end
    if (bus_req && o_avs_waitrequest) begin
      if (i_avs_address == msf_pkg::ADDR_POLARITY_TACHO) begin
        next_readdata = {24'h0, output_polarity_tacho_edge};
      end else if (i_avs_address == msf_pkg::ADDR_Z_FILTER) begin
        next_readdata = {24'h0, z_event_filter};
      end else if (i_avs_address == msf_pkg::ADDR_SAMPLING_CLK) begin
        next_readdata = {24'h0, sampling_clock_config};
      end else if (i_avs_address == msf_pkg::ADDR_STATUS) begin
        next_readdata = {29'h0, speed_mode, z_blank_active, unused_in_eff};
      end else begin
        next_readdata = 32'h0;
      end
    end
  end

  // ****************************************
  // peripheral clock enable and config carrier
  // ****************************************
  always_comb begin
    next_pdiv = pdiv + 3'h1;
    if (pdiv == 3'(msf_pkg::SYS_PER_PERIPH - 1)) begin
      next_pdiv = 3'h0;
    end
  end
  assign cfg.periph_tick = (pdiv == 3'h0);
  assign cfg.z_sample_count = z_event_filter[msf_pkg::ZCOUNT_HI:msf_pkg::ZCOUNT_LO];
  assign cfg.z_blank_window = z_event_filter[msf_pkg::ZWIN_HI:0];
  assign cfg.sampling_clock_select =
    sampling_clock_config[msf_pkg::SCLK_SEL_HI:msf_pkg::SCLK_SEL_LO];
  assign cfg.sensor_mode_select = i_sensor_mode_select;
  assign cfg.use_pwm_rate = i_pwm_sample_mode;
  // with the master output enable set the sampling is left running
  assign cfg.sample_gate = i_master_output_enable ||
                           sampling_clock_config[msf_pkg::ZVALID_BIT];

  msf_z_filter u_z_filter (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .cfg(cfg),
    .i_d_event(i_d_event),
    .i_z_sample(i_z_sample),
    .i_pwm_tick(i_pwm_tick),
    .o_z_event(z_ev),
    .o_blanking(z_blank_active)
  );

  // ****************************************
  // pin-side outputs
  // ****************************************
  logic [5:0] next_channel;
  logic next_tacho_capture;
  always_comb begin
    next_channel = i_channel;
    if (!i_three_phase_independent) begin
      next_channel = i_channel ^ output_polarity_tacho_edge[msf_pkg::POL_HI:0];
    end
    case (tacho_edge_select)
      msf_pkg::TACHO_RISE: next_tacho_capture = i_tacho_in && !tacho_d;
      msf_pkg::TACHO_FALL: next_tacho_capture = !i_tacho_in && tacho_d;
      msf_pkg::TACHO_BOTH: next_tacho_capture = i_tacho_in ^ tacho_d;
      default: next_tacho_capture = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      output_polarity_tacho_edge <= msf_pkg::RST_POLARITY_TACHO;
      z_event_filter <= msf_pkg::RST_Z_FILTER;
      sampling_clock_config <= msf_pkg::RST_SAMPLING_CLK;
      o_avs_readdata <= 32'h0;
      o_avs_waitrequest <= 1'b1;
      pdiv <= 3'h0;
      tacho_d <= 1'b0;
      o_channel <= 6'h0;
      o_speed_sensor_mode <= 1'b0;
      o_tacho_capture <= 1'b0;
      o_encoder_capture <= 1'b0;
      o_encoder_capture_source <= 1'b0;
      o_inputs_ground <= 1'b0;
      o_inputs_hiz <= 1'b0;
      o_z_event <= 1'b0;
      o_blanking <= 1'b0;
    end else begin
      output_polarity_tacho_edge <= next_output_polarity_tacho_edge;
      z_event_filter <= next_z_event_filter;
      sampling_clock_config <= next_sampling_clock_config;
      o_avs_readdata <= next_readdata;
      o_avs_waitrequest <= next_waitrequest;
      pdiv <= next_pdiv;
      tacho_d <= i_tacho_in;
      o_channel <= next_channel;
      o_speed_sensor_mode <= speed_mode;
      o_tacho_capture <= next_tacho_capture;
      o_encoder_capture_source <= sampling_clock_config[msf_pkg::ENC_SRC_BIT];
      o_encoder_capture <= speed_mode && (sampling_clock_config[msf_pkg::ENC_SRC_BIT] ?
                           i_motor_timer_high_read : i_rtc_tick);
      o_inputs_ground <= unused_in_eff && !sampling_clock_config[msf_pkg::HIZ_SEL_BIT];
      o_inputs_hiz <= unused_in_eff && sampling_clock_config[msf_pkg::HIZ_SEL_BIT];
      o_z_event <= z_ev;
      o_blanking <= z_blank_active;
    end
  end
endmodule : msf_top
`default_nettype wire

// ==== logic/msf_pkg.sv ====
// Purpose: constants for the motor sense filter and configuration block
// Assumes: 20 MHz system clock, 4 MHz nominal peripheral clock
// Notes: register offsets are byte addresses on a 32-bit Avalon-MM bus
//
// Functional notes
// - tacho edge select 01 rising, 10 falling, 11 both; non-zero means speed sensor mode
// - tacho edge select 00 means position sensor or sensorless six-step mode
// - each polarity bit: zero drives channel active high, one active low
// - polarity bits ignored while three-phase independent bit is set
// - z event needs field plus one consecutive valid samples, 1 to 16
// - z samples taken at sampling clock rate or at pwm rate
// - window code 0-7 gives 5 to 40 us, 8-15 gives 60 to 200 us
// - z detection suppressed while blanking window runs, resumes after it elapses
// - z sampling validate gates sampling while master output enable is clear
// - sampling clock select 00 1 MHz, 01 500k, 10 250k, 11 125 kHz
// - times derive from counting peripheral clock cycles, specified at 4 MHz
// - encoder capture source: zero rtc interrupt, one timer high byte read
// - unused input select effective only with three-phase bit clear, tacho select 00, sensorless
// - effective unused input select: zero grounds inputs, one puts them hi-z
// - z event filter register resets to 0Fh
// - polarity/tacho and sampling clock registers reset to 00h
package msf_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_POLARITY_TACHO = 4'h0;
  localparam logic [3:0] ADDR_Z_FILTER = 4'h4;
  localparam logic [3:0] ADDR_SAMPLING_CLK = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam logic [7:0] RST_POLARITY_TACHO = 8'h00;
  localparam logic [7:0] RST_Z_FILTER = 8'h0F;
  localparam logic [7:0] RST_SAMPLING_CLK = 8'h00;
  localparam logic [7:0] SCR_WRITE_MASK = 8'h8F;
  // ****************************************
  // field positions
  // ****************************************
  localparam int TACHO_SEL_HI = 7;
  localparam int TACHO_SEL_LO = 6;
  localparam int POL_HI = 5;
  localparam int ZCOUNT_HI = 7;
  localparam int ZCOUNT_LO = 4;
  localparam int ZWIN_HI = 3;
  localparam int ZVALID_BIT = 7;
  localparam int SCLK_SEL_HI = 3;
  localparam int SCLK_SEL_LO = 2;
  localparam int ENC_SRC_BIT = 1;
  localparam int HIZ_SEL_BIT = 0;
  localparam logic [1:0] TACHO_RISE = 2'h1;
  localparam logic [1:0] TACHO_FALL = 2'h2;
  localparam logic [1:0] TACHO_BOTH = 2'h3;
  // ****************************************
  // timing, peripheral clock is the reference
  // ****************************************
  localparam int PERIPH_KHZ = 4000;
  localparam int SYS_KHZ = 20000;
  localparam int SYS_PER_PERIPH = SYS_KHZ / PERIPH_KHZ;
  localparam int WIN_SHORT_STEP_US = 5;
  localparam int WIN_LONG_BASE_US = 60;
  localparam int WIN_LONG_STEP_US = 20;
  localparam int WIN_SPLIT = 8;
  localparam int SCLK_BASE_KHZ = 1000;
  localparam int SCLK_BASE_TICKS = PERIPH_KHZ / SCLK_BASE_KHZ;
  localparam int TICKS_PER_US = PERIPH_KHZ / 1000;
  localparam int CNT_W = 10;
  typedef enum logic [1:0] {MSF_IDLE, MSF_BLANK, MSF_HUNT} msf_state_t;
endpackage : msf_pkg

// ==== logic/msf_cfg_if.sv ====
// Purpose: carries decoded configuration to the z event filter
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface msf_cfg_if;
  logic [3:0] z_sample_count;
  logic [3:0] z_blank_window;
  logic [1:0] sampling_clock_select;
  logic sensor_mode_select;
  logic sample_gate;
  logic use_pwm_rate;
  logic periph_tick;
  modport src (output z_sample_count, z_blank_window, sampling_clock_select,
               sensor_mode_select, sample_gate, use_pwm_rate, periph_tick);
  modport dst (input z_sample_count, z_blank_window, sampling_clock_select,
               sensor_mode_select, sample_gate, use_pwm_rate, periph_tick);
endinterface : msf_cfg_if
`default_nettype wire

// ==== logic/msf_z_filter.sv ====
// Purpose: blanking window and consecutive sample filter for z events
// Assumes: periph_tick is a one-cycle pulse at the peripheral clock rate
// Notes: z event out is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module msf_z_filter (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  msf_cfg_if.dst cfg,
  input wire logic i_d_event,
  input wire logic i_z_sample,
  input wire logic i_pwm_tick,
  output logic o_z_event,
  output logic o_blanking
);
  msf_pkg::msf_state_t state, next_state;
  logic [msf_pkg::CNT_W-1:0] win_cnt, next_win_cnt;
  logic [4:0] run_cnt, next_run_cnt;
  logic next_z_event;

  // window length in peripheral ticks
  function automatic logic [msf_pkg::CNT_W-1:0] win_ticks(input logic [3:0] code);
    int us;
    if (code < 4'(msf_pkg::WIN_SPLIT)) begin
      us = (int'(code) + 1) * msf_pkg::WIN_SHORT_STEP_US;
    end else begin
      us = msf_pkg::WIN_LONG_BASE_US +
           (int'(code) - msf_pkg::WIN_SPLIT) * msf_pkg::WIN_LONG_STEP_US;
    end
    return msf_pkg::CNT_W'(us * msf_pkg::TICKS_PER_US);
  endfunction : win_ticks

  // ****************************************
  // sampling clock divider
  // ****************************************
  // 1 MHz base then divided by 1, 2, 4 or 8
  logic [1:0] base_cnt, next_base_cnt;
  logic base_tick;
  always_comb begin
    next_base_cnt = base_cnt;
    base_tick = 1'b0;
    if (cfg.periph_tick) begin
      if (base_cnt == 2'(msf_pkg::SCLK_BASE_TICKS - 1)) begin
        next_base_cnt = 2'h0;
        base_tick = 1'b1;
      end else begin
        next_base_cnt = base_cnt + 2'h1;
      end
    end
  end

  // ****************************************
  // blanking and filter state machine
  // ****************************************
  logic z_take;
  logic div_tick;
  logic [2:0] div_cnt, next_div_cnt;
  always_comb begin
    next_div_cnt = div_cnt;
    div_tick = 1'b0;
    if (base_tick) begin
      next_div_cnt = div_cnt + 3'h1;
      div_tick = ((div_cnt & ((3'h1 << cfg.sampling_clock_select) - 3'h1)) == 3'h0);
    end
    z_take = (cfg.use_pwm_rate ? i_pwm_tick : div_tick) && cfg.sample_gate;
  end

  always_comb begin
    next_state = state;
    next_win_cnt = win_cnt;
    next_run_cnt = run_cnt;
    next_z_event = 1'b0;
    if (i_d_event && !cfg.sensor_mode_select) begin
      next_state = msf_pkg::MSF_BLANK;
      next_win_cnt = win_ticks(cfg.z_blank_window);
      next_run_cnt = 5'h0;
    end else begin
      case (state)
        msf_pkg::MSF_IDLE: begin
          next_state = msf_pkg::MSF_HUNT;
          next_run_cnt = 5'h0;
        end
        msf_pkg::MSF_BLANK: begin
          if (cfg.periph_tick) begin
            if (win_cnt <= msf_pkg::CNT_W'(1)) begin
              next_state = msf_pkg::MSF_HUNT;
              next_run_cnt = 5'h0;
            end else begin
              next_win_cnt = win_cnt - msf_pkg::CNT_W'(1);
            end
          end
        end
        msf_pkg::MSF_HUNT: begin
          if (z_take) begin
            if (!i_z_sample) begin
              next_run_cnt = 5'h0;
            end else if (run_cnt == {1'b0, cfg.z_sample_count}) begin
              next_z_event = 1'b1;
              next_run_cnt = 5'h0;
            end else begin
              next_run_cnt = run_cnt + 5'h1;
            end
          end
        end
        default: next_state = msf_pkg::MSF_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state <= msf_pkg::MSF_IDLE;
      win_cnt <= '0;
      run_cnt <= 5'h0;
      base_cnt <= 2'h0;
      div_cnt <= 3'h0;
      o_z_event <= 1'b0;
      o_blanking <= 1'b0;
    end else begin
      state <= next_state;
      win_cnt <= next_win_cnt;
      run_cnt <= next_run_cnt;
      base_cnt <= next_base_cnt;
      div_cnt <= next_div_cnt;
      o_z_event <= next_z_event;
      o_blanking <= (next_state == msf_pkg::MSF_BLANK);
    end
  end
endmodule : msf_z_filter
`default_nettype wire

// ==== verif/msf_top_props.sv ====
// Purpose: port-level checks of the motor sense filter block
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound into every msf_top instance
`timescale 1ns/1ps
`default_nettype none
module msf_top_props (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_three_phase_independent,
  input wire logic i_sensor_mode_select,
  input wire logic i_d_event,
  input wire logic [5:0] i_channel,
  input wire logic [5:0] o_channel,
  input wire logic o_speed_sensor_mode,
  input wire logic o_encoder_capture,
  input wire logic o_inputs_ground,
  input wire logic o_inputs_hiz,
  input wire logic o_z_event,
  input wire logic o_blanking
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_wait_one_state: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("waitrequest held past one wait state");
  a_wait_low_once: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_resv_read_zero: assert property (!o_avs_waitrequest && i_avs_read && i_avs_address == 4'h8
    |-> o_avs_readdata[6:4] == 3'h0) else $error("reserved bits read non-zero");
  a_pol_bypass: assert property ($past(i_three_phase_independent)
    |-> o_channel == $past(i_channel)) else $error("polarity applied in three-phase mode");
  a_unused_cause: assert property ((o_inputs_ground || o_inputs_hiz) |-> !o_speed_sensor_mode
    && !$past(i_three_phase_independent) && !$past(i_sensor_mode_select))
    else $error("unused input handling outside its mode");
  a_gnd_hiz_excl: assert property (!(o_inputs_ground && o_inputs_hiz))
    else $error("inputs grounded and hi-z together");
  a_blank_quiet: assert property (o_blanking |-> !o_z_event)
    else $error("z event during blanking");
  a_sensor_no_blank: assert property (i_sensor_mode_select && $past(i_sensor_mode_select)
    && i_d_event && !o_blanking |-> ##2 !o_blanking)
    else $error("blanking started in sensor mode");
  a_z_single: assert property (o_z_event |=> !o_z_event)
    else $error("z event wider than one cycle");
  a_blank_min: assert property ($rose(o_blanking) |=> o_blanking [*8])
    else $error("blanking window too short");
  a_enc_speed: assert property (o_encoder_capture |-> o_speed_sensor_mode)
    else $error("encoder capture outside speed mode");
  c_z_event: cover property (o_z_event);
  c_blank: cover property ($rose(o_blanking));
  c_enc: cover property (o_encoder_capture);
endmodule : msf_top_props
bind msf_top msf_top_props chk_u (.i_clk_sys, .i_rst_n, .i_avs_address, .i_avs_read,
  .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_three_phase_independent,
  .i_sensor_mode_select, .i_d_event, .i_channel, .o_channel, .o_speed_sensor_mode,
  .o_encoder_capture, .o_inputs_ground, .o_inputs_hiz, .o_z_event, .o_blanking);
`default_nettype wire

// ==== verif/msf_motor_model.sv ====
// Purpose: inverter side model, pwm sample strobe and d event pulses
// Assumes: one clock domain
// Notes: i_pwm_div sets a prompt or slow pwm rate
`timescale 1ns/1ps
`default_nettype none
module msf_motor_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_d_req,
  input wire logic [7:0] i_pwm_div,
  output logic o_pwm_tick,
  output logic o_d_event
);
  logic [7:0] pwm_cnt;
  // ****************************************
  // strobes, registered so they change just after an edge
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    pwm_cnt <= (!i_rst_n || pwm_cnt == i_pwm_div) ? 8'h00 : pwm_cnt + 8'h01;
    o_pwm_tick <= i_rst_n && pwm_cnt == i_pwm_div;
    o_d_event <= i_rst_n && i_d_req;
  end
endmodule : msf_motor_model
`default_nettype wire

// ==== verif/tb_motor_sense_filter_config.sv ====
// Purpose: self-checking bench for msf_top
// Assumes: 20 MHz clock, one wait state per bus access
// Notes: window and sample times checked within a few cycles of tick phase
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_motor_sense_filter_config;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, three_ph = 1'b0, sens = 1'b0;
  logic out_en = 1'b0, pwmm = 1'b0, d_req = 1'b0, z = 1'b0, tacho = 1'b0, rtc = 1'b0, thr = 1'b0;
  logic [3:0] addr = 4'h0, be = 4'hF;
  logic [31:0] wdata = 32'h0, rdata;
  logic [5:0] ch = 6'h00, och;
  logic [7:0] pwm_div = 8'h28, v, q;
  logic wait_r, pwm_tick, d_ev, spd, tcap, ecap, esrc, gnd, hiz, zev, blank;
  int fail_count = 0, tests_run = 0, seed = 65, n_tcap = 0, n_ecap = 0, n_zev = 0, k, t;
  logic [7:0] win_codes [4] = '{8'h00, 8'h07, 8'h08, 8'h0F};
  always #25 clk = ~clk;
  always @(posedge clk) begin
    n_tcap += int'(tcap);
    n_zev += int'(zev);
    n_ecap += int'(ecap);
  end
  msf_top dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_r), .i_three_phase_independent(three_ph), .i_sensor_mode_select(sens),
    .i_master_output_enable(out_en), .i_pwm_sample_mode(pwmm), .i_pwm_tick(pwm_tick),
    .i_d_event(d_ev), .i_z_sample(z), .i_tacho_in(tacho), .i_rtc_tick(rtc),
    .i_motor_timer_high_read(thr), .i_channel(ch), .o_channel(och), .o_speed_sensor_mode(spd),
    .o_tacho_capture(tcap), .o_encoder_capture(ecap), .o_encoder_capture_source(esrc),
    .o_inputs_ground(gnd), .o_inputs_hiz(hiz), .o_z_event(zev), .o_blanking(blank));
  msf_motor_model pm_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_d_req(d_req),
    .i_pwm_div(pwm_div), .o_pwm_tick(pwm_tick), .o_d_event(d_ev));
  // ****************************************
  // helpers
  // ****************************************
  task automatic results();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // request held until waitrequest is seen low, data taken at that edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h000000, d};
    for (i = 0; i < 20 && wait_r !== 1'b0; i++) @(posedge clk);
    if (i > 0 && wait_r === 1'b0) q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (i == 20) begin
      fail_count++;
      results();
    end
  endtask : bus
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask : rchk
  function automatic int win_cyc(input int c);
    return 20 * ((c < 8) ? 5 * (c + 1) : 60 + 20 * (c - 8));
  endfunction : win_cyc
  // d pulse, then length of the blanking window it starts
  task automatic blank_len(input int c);
    int n, m;
    d_req <= 1'b1;
    cyc(1);
    d_req <= 1'b0;
    for (n = 0; n < 10 && blank !== 1'b1; n++) cyc(1);
    m = n_zev;
    for (n = 0; n < win_cyc(c) + 20 && blank === 1'b1; n++) cyc(1);
    `CHK(n > win_cyc(c) - 8 && n < win_cyc(c) + 8, 1'b1)
    `CHK(n_zev - m, 0)
  endtask : blank_len
  task automatic zwait(input int lo, input int hi, input logic hit);
    int n;
    for (n = 0; n < hi && zev !== 1'b1; n++) cyc(1);
    `CHK(n >= lo && n < hi, hit)
  endtask : zwait
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    cyc(12);
    rst_n <= 1'b1;
    rchk(4'h0, 8'h00);
    rchk(4'h4, 8'h0F);
    rchk(4'h8, 8'h00);
    rchk(4'hC, 8'h01);
    rchk(4'h2, 8'h00);
    be <= 4'hE;
    bus(1'b1, 4'h4, 8'h55);
    be <= 4'hF;
    rchk(4'h4, 8'h0F);
    for (k = 0; k < 8; k++) begin
      v = (k < 2) ? {k[0], 7'h00} : 8'($random(seed));
      ch <= 6'($random(seed));
      bus(1'b1, 4'h0, v);
      bus(1'b1, 4'h8, v & 8'h8F);
      cyc(3);
      `CHK(och, ch ^ v[5:0])
      `CHK(spd, |v[7:6])
      `CHK(esrc, v[1])
      `CHK({gnd, hiz}, (v[7:6] == 2'h0) ? {!v[0], v[0]} : 2'h0)
      three_ph <= 1'b1;
      sens <= k[0];
      cyc(3);
      `CHK(och, ch)
      `CHK({gnd, hiz}, 2'h0)
      three_ph <= 1'b0;
      sens <= 1'b0;
      rchk(4'h0, v);
      rchk(4'h8, v & 8'h8F);
    end
    for (t = 0; t < 4; t++) begin
      bus(1'b1, 4'h0, {t[1:0], 6'h00});
      k = n_tcap;
      repeat (4) begin
        tacho <= ~tacho;
        cyc(6);
      end
      `CHK(n_tcap - k, (t == 3) ? 4 : (t == 0) ? 0 : 2)
    end
    bus(1'b1, 4'h0, 8'h40);
    for (t = 0; t < 2; t++) begin
      bus(1'b1, 4'h8, {6'h00, t[0], 1'b0});
      k = n_ecap;
      repeat (3) begin
        rtc <= 1'b1;
        cyc(1);
        rtc <= 1'b0;
        thr <= 1'b1;
        cyc(1);
        thr <= 1'b0;
        cyc(4);
      end
      `CHK(n_ecap - k, 3)
    end
    bus(1'b1, 4'h0, 8'h00);
    // z filter at 1 MHz: first strobe phase is unknown, so allow one period
    bus(1'b1, 4'h8, 8'h80);
    t = $random(seed) & 7;
    bus(1'b1, 4'h4, {t[3:0], 4'h0});
    z <= 1'b1;
    blank_len(0);
    zwait(t * 20, (t + 1) * 20 + 10, 1'b1);
    z <= 1'b0;
    bus(1'b1, 4'h4, 8'h30);
    blank_len(0);
    z <= 1'b1;
    cyc(50);
    z <= 1'b0;
    cyc(30);
    z <= 1'b1;
    zwait(60, 90, 1'b1);
    z <= 1'b0;
    foreach (win_codes[i]) begin
      bus(1'b1, 4'h4, win_codes[i]);
      blank_len(win_codes[i]);
    end
    bus(1'b1, 4'h4, 8'h10);
    pwmm <= 1'b1;
    z <= 1'b1;
    blank_len(0);
    zwait(41, 92, 1'b1);
    pwmm <= 1'b0;
    z <= 1'b0;
    bus(1'b1, 4'h8, 8'h00);
    z <= 1'b1;
    blank_len(0);
    zwait(0, 300, 1'b0);
    out_en <= 1'b1;
    zwait(0, 60, 1'b1);
    // slowest sampling clock, two samples need one to two periods of 160 cycles
    bus(1'b1, 4'h8, 8'h8C);
    blank_len(0);
    zwait(160, 330, 1'b1);
    z <= 1'b0;
    sens <= 1'b1;
    cyc(2);
    d_req <= 1'b1;
    cyc(1);
    d_req <= 1'b0;
    cyc(20);
    `CHK(blank, 1'b0)
    results();
  end
endmodule : tb_motor_sense_filter_config
`default_nettype wire
